// [dv/light_sensor_cycle_and_alarm_tb.sv]
// self-checking bench for the light sensor cycle and alarm core
`timescale 1ns/1ps
module light_sensor_cycle_and_alarm_tb
    import lsca_pkg::*;
;
    localparam int STEP = 4;
    logic          clk_sys;
    logic          rst_b;
    logic          clkEn;
    logic [16:0]   ch0Raw;
    logic [7:0]    regRdData;
    logic          oscRun;
    logic          adcRun;
    logic          intPinOut;
    logic          intPinOeN;
    logic          cmdValid;
    logic [7:0]    cmdByte;
    lsca_reg_req_t regReq;
    int            failures;
    int            comparisons;
    int            n;
    int            nTab[5] = '{1, 2, 3, 5, 10};

    lsca_core #(.STEP_CYCLES_P(STEP)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
        .regReq(regReq), .regRdData(regRdData), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .ch0Raw(ch0Raw), .oscRun(oscRun), .adcRun(adcRun), .intPinOut(intPinOut),
        .intPinOeN(intPinOeN));
    lsca_host_model host (.clk_sys(clk_sys), .regRdData(regRdData), .regReq(regReq),
        .cmdValid(cmdValid), .cmdByte(cmdByte));

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk({9'h000, d}, {9'h000, exp});
    endtask

    // count cycles until the pin is pulled low, bounded
    task automatic waitAlarm(input int lim, output int k);
        k = 0;
        // first look half a cycle on, never in the edge that launches the pin
        @(negedge clk_sys);
        while (intPinOeN !== 1'b0 && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    task automatic setCh0(input logic [16:0] v);
        @(posedge clk_sys);
        ch0Raw <= v;
    endtask

    // reset values, unmapped read and idle outputs
    task automatic tReset();
        rdChk(ADDR_ENABLE, 8'h00);
        rdChk(ADDR_ITIME, 8'hFF);
        rdChk(ADDR_WAIT_TIME, 8'hFF);
        rdChk(ADDR_ALARM_PERSISTENCE, 8'h00);
        rdChk(5'h1F, 8'h00);
        chk({16'h0000, intPinOeN}, 17'h00001);
        chk({16'h0000, intPinOut}, 17'h00000);
    endtask

    // threshold byte pairs read back, then set low 0100 high 0200
    task automatic tThresh();
        for (int i = 0; i < 4; i++) begin
            host.wr(ADDR_THR_LL + 5'(i), 8'hA0 + 8'(i));
            rdChk(ADDR_THR_LL + 5'(i), 8'hA0 + 8'(i));
        end
        host.wr(ADDR_THR_LL, 8'h00);
        host.wr(ADDR_THR_LH, 8'h01);
        host.wr(ADDR_THR_HL, 8'h00);
        host.wr(ADDR_THR_HH, 8'h02);
    endtask

    // power and measure enables gate oscillator and converter
    task automatic tEnable();
        host.wr(ADDR_ENABLE, 8'h01);
        cyc(3);
        chk({16'h0000, oscRun}, 17'h00001);
        chk({16'h0000, adcRun}, 17'h00000);
        host.wr(ADDR_ENABLE, 8'h03);
        cyc(5);
        chk({16'h0000, adcRun}, 17'h00001);
        host.wr(ADDR_ENABLE, 8'h00);
        cyc(2);
        chk({15'h0000, oscRun, adcRun}, 17'h00000);
    endtask

    // persistence zero fires in range; mask off keeps the pin quiet
    task automatic tEvery();
        setCh0(17'h00150);
        host.wr(ADDR_ALARM_PERSISTENCE, 8'h00);
        host.wr(ADDR_ENABLE, 8'h13);
        waitAlarm(12, n);
        chk({16'h0000, intPinOeN}, 17'h00000);
        rdChk(ADDR_STATUS, 8'h11);
        host.wr(ADDR_ENABLE, 8'h03);
        host.clr();
        cyc(1);
        chk({16'h0000, intPinOeN}, 17'h00001);
        waitAlarm(20, n);
        chk(17'(n), 17'd20);
    endtask

    // consecutive out-of-range counts per code, alternating sides
    task automatic tPers();
        int l;
        l = 2 * STEP;
        host.wr(ADDR_ITIME, 8'hFE);
        host.wr(ADDR_ENABLE, 8'h13);
        for (int i = 0; i < 5; i++) begin
            host.wr(ADDR_ALARM_PERSISTENCE, 8'(i + 1));
            setCh0(17'h00150);
            cyc(2 * l + 2);
            host.clr();
            setCh0(i[0] ? 17'h00050 : 17'h00250);
            waitAlarm(nTab[i] * l + 3, n);
            chk(17'(n >= (nTab[i] - 1) * l && n <= nTab[i] * l + 2), 17'h00001);
            setCh0(17'h00150);
            cyc(2 * l + 2);
            chk({16'h0000, intPinOeN}, 17'h00000);
            host.clr();
            cyc(1);
            chk({16'h0000, intPinOeN}, 17'h00001);
        end
        setCh0(17'h1FFFF);
        cyc(2 * l + 2);
        rdChk(ADDR_CH0_LO, 8'hFF);
        rdChk(ADDR_CH0_HI, 8'hFF);
    endtask

    // alarm period with wait timer, long wait and wait off
    task automatic tWait();
        int p;
        host.wr(ADDR_ENABLE, 8'h00);
        host.wr(ADDR_ITIME, 8'hFF);
        host.wr(ADDR_ALARM_PERSISTENCE, 8'h00);
        host.wr(ADDR_WAIT_TIME, 8'hFE);
        setCh0(17'h00150);
        for (int m = 0; m < 3; m++) begin
            host.wr(ADDR_CONFIG, (m == 1) ? 8'h02 : 8'h00);
            host.wr(ADDR_ENABLE, (m == 2) ? 8'h13 : 8'h1B);
            p = STEP + ((m == 2) ? 0 : ((m == 1) ? 24 : 2) * STEP);
            host.clr();
            waitAlarm(p + 20, n);
            host.clr();
            waitAlarm(p + 20, n);
            chk(17'(n >= p - 6 && n <= p + 2), 17'h00001);
        end
    endtask

    // sleep after alarm drops the power bit
    task automatic tSleep();
        host.wr(ADDR_ENABLE, 8'h53);
        cyc(3 * STEP + 6);
        rdChk(ADDR_ENABLE, 8'h52);
        chk({16'h0000, oscRun}, 17'h00000);
        // a write while the clock enable is low must not land
        @(posedge clk_sys);
        clkEn <= 1'b0;
        host.wr(ADDR_ENABLE, 8'h03);
        @(posedge clk_sys);
        clkEn <= 1'b1;
        rdChk(ADDR_ENABLE, 8'h52);
    endtask

    // main sequence
    initial begin
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        clkEn = 1'b1;
        ch0Raw = 17'h00000;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        cyc(4);
        tReset();
        tThresh();
        tEnable();
        tEvery();
        tPers();
        tWait();
        tSleep();
        print_verdict();
    end

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end
endmodule

// [dv/lsca_host_model.sv]
// host-side model: byte register writes, reads and the alarm clear command
`timescale 1ns/1ps
module lsca_host_model
    import lsca_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic [7:0]     regRdData,
    output lsca_reg_req_t       regReq,
    output logic                cmdValid,
    output logic [7:0]          cmdByte
);
    // idle bus at time zero
    initial begin
        regReq = '0;
        cmdValid = 1'b0;
        cmdByte = 8'h00;
    end

    // one byte write, reserved bits of enable and persistence forced to zero
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_ENABLE) v = d & 8'h5B;
        if (a == ADDR_ALARM_PERSISTENCE) v = d & 8'h0F;
        @(posedge clk_sys);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys);
        regReq <= '0;
    endtask

    // one byte read, data taken once it has settled
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        regReq <= '0;
        @(negedge clk_sys);
        d = regRdData;
    endtask

    // special function command that drops a pending alarm
    task automatic clr();
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdByte <= {1'b1, CMD_TYPE_SPECIAL, CMD_FN_INT_CLEAR};
        @(posedge clk_sys);
        cmdValid <= 1'b0;
    endtask
endmodule

// [hw/lsca_core.sv]
// light sensor cycle timers, alarm thresholds and persistence filter
// Notes on behaviour
// RL1: sleep-after-alarm powers down at cycle end
// RL2: alarms only raised while mask bit set
// RL3: wait enable turns the wait timer on/off
// RL4: measure enable starts and stops the converter
// RL5: power bit gates timers and converter
// RL6: host writes zero to reserved bits
// RL7: integration lasts 256 minus value steps
// RL8: integration register resets to FF
// RL9: wait step 2.73 ms, twelvefold when long
// RL10: wait register gives 256 minus value steps
// RL11: wait register resets to FF
// RL12: host programs wait before measure enable
// RL13: result outside thresholds drives interrupt pin
// RL14: thresholds are 16-bit byte pairs 04..07
// RL15: only channel 0 compared against thresholds
// RL16: persistence zero interrupts every cycle
// RL17: nonzero persistence needs N consecutive out-of-range
// RL18: special clear command drops pending interrupt once
// RL19: status shows valid and interrupt bits
// RL20: cycle repeats; in-range result restarts count
// RL21: interrupt holds until clear command
`timescale 1ns/1ps
module lsca_core
    import lsca_pkg::*;
#(
    parameter int STEP_CYCLES_P = STEP_CYCLES
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    input  wire logic          clkEn,
    input  wire lsca_reg_req_t regReq,
    output logic [7:0]         regRdData,
    input  wire logic          cmdValid,
    input  wire logic [7:0]    cmdByte,
    input  wire logic [16:0]   ch0Raw,
    output logic               oscRun,
    output logic               adcRun,
    output logic               intPinOut,
    output logic               intPinOeN
);

    localparam logic [19:0] STEP_LAST = 20'(STEP_CYCLES_P - 1);

    // threshold count needed for a persistence code
    function automatic logic [5:0] persLimit(input logic [3:0] code);
        if (code <= ALARM_PERSISTENCE_DIRECT_MAX) begin
            persLimit = {2'b00, code};
        end else begin
            persLimit = 6'(({2'b00, code} - {2'b00, ALARM_PERSISTENCE_DIRECT_MAX}) * ALARM_PERSISTENCE_STEP);
        end
    endfunction

    // special function byte that clears the alarm
    function automatic logic isIntClear(input logic [7:0] b);
        isIntClear = (b[6:5] == CMD_TYPE_SPECIAL) && (b[4:0] == CMD_FN_INT_CLEAR);
    endfunction

    lsca_state_t q;
    lsca_state_t d;
    logic [1:0]  rstPipe_q;
    logic        rstSync_n;
    logic        stepEnd;
    logic        integEnd;
    logic        outOfRange;
    logic        hit;
    logic        clearReq;
    logic        sleepNow;
    logic        enableWrite;
    logic [15:0] ch0Clamp;
    logic [5:0]  oorNext;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    // next-state logic for the whole core
    always_comb begin
        d           = q;
        integEnd    = 1'b0;
        hit         = 1'b0;
        sleepNow    = 1'b0;
        oorNext     = q.oorCnt;
        stepEnd     = (q.tick == STEP_LAST);
        clearReq    = cmdValid && isIntClear(cmdByte);  // RL18
        enableWrite = regReq.wr && (regReq.addr == ADDR_ENABLE);
        // saturate the raw channel 0 accumulation
        ch0Clamp    = (ch0Raw > CH0_SAT) ? CH0_SAT[15:0] : ch0Raw[15:0];  // RL7
        // channel 0 only, outside the low/high window
        outOfRange  = (ch0Clamp < q.thrLow) || (ch0Clamp > q.thrHigh);  // RL13 RL15

        // register writes
        if (regReq.wr) begin
            case (regReq.addr)
                ADDR_ENABLE: d.enable        = regReq.wdata;
                ADDR_ITIME:  d.itime         = regReq.wdata;
                ADDR_WAIT_TIME:  d.wait_time         = regReq.wdata;
                ADDR_THR_LL: d.thrLow[7:0]   = regReq.wdata;  // RL14
                ADDR_THR_LH: d.thrLow[15:8]  = regReq.wdata;  // RL14
                ADDR_THR_HL: d.thrHigh[7:0]  = regReq.wdata;  // RL14
                ADDR_THR_HH: d.thrHigh[15:8] = regReq.wdata;  // RL14
                ADDR_ALARM_PERSISTENCE:   d.alarm_persistence          = regReq.wdata;
                ADDR_CONFIG: d.cfg           = regReq.wdata;
                default: ;
            endcase
        end

        // registered read data
        if (regReq.rd) begin
            case (regReq.addr)
                ADDR_ENABLE: d.rdData = q.enable;
                ADDR_ITIME:  d.rdData = q.itime;
                ADDR_WAIT_TIME:  d.rdData = q.wait_time;
                ADDR_THR_LL: d.rdData = q.thrLow[7:0];
                ADDR_THR_LH: d.rdData = q.thrLow[15:8];
                ADDR_THR_HL: d.rdData = q.thrHigh[7:0];
                ADDR_THR_HH: d.rdData = q.thrHigh[15:8];
                ADDR_ALARM_PERSISTENCE:   d.rdData = q.alarm_persistence;
                ADDR_CONFIG: d.rdData = q.cfg;
                ADDR_STATUS: begin
                    d.rdData                 = 8'h00;
                    d.rdData[BIT_STAT_VALID] = q.valid;  // RL19
                    d.rdData[BIT_STAT_ALARM] = q.alarm;  // RL19
                end
                ADDR_CH0_LO: d.rdData = q.ch0[7:0];
                ADDR_CH0_HI: d.rdData = q.ch0[15:8];
                default:     d.rdData = 8'h00;
            endcase
        end

        // measurement cycle: integrate, then optional wait
        if (!(d.enable[BIT_OSC_POWER] && d.enable[BIT_MEAS_EN])) begin
            d.phase   = PH_IDLE;  // RL4 RL5
            d.tick    = 20'h00000;
            d.longIdx = 4'h0;
            d.valid   = 1'b0;     // RL19
        end else begin
            d.tick = stepEnd ? 20'h00000 : q.tick + 20'h00001;
            case (q.phase)
                PH_IDLE: begin
                    d.phase   = PH_INTEG;
                    d.stepIdx = d.itime;
                    d.tick    = 20'h00000;
                end
                PH_INTEG: begin
                    if (stepEnd) begin
                        if (q.stepIdx == STEP_IDX_LAST) begin
                            integEnd = 1'b1;  // RL7
                        end else begin
                            d.stepIdx = q.stepIdx + 8'h01;
                        end
                    end
                end
                PH_WAIT: begin
                    if (!d.enable[BIT_WAIT_EN]) begin
                        d.phase   = PH_INTEG;  // RL3
                        d.stepIdx = d.itime;
                        d.tick    = 20'h00000;
                        d.longIdx = 4'h0;
                    end else if (stepEnd) begin
                        if (q.cfg[BIT_LONG_WAIT] && q.longIdx != LONG_WAIT_LAST) begin
                            d.longIdx = q.longIdx + 4'h1;  // RL9
                        end else begin
                            d.longIdx = 4'h0;
                            if (q.stepIdx == STEP_IDX_LAST) begin
                                d.phase   = PH_INTEG;  // RL10 RL20
                                d.stepIdx = d.itime;
                            end else begin
                                d.stepIdx = q.stepIdx + 8'h01;
                            end
                        end
                    end
                end
                default: d.phase = PH_IDLE;
            endcase
        end

        // end of integration: capture, filter, next phase
        if (integEnd) begin
            d.ch0   = ch0Clamp;
            d.valid = 1'b1;  // RL19
            if (q.alarm_persistence[3:0] == 4'h0) begin
                hit = 1'b1;  // RL16
            end else if (outOfRange) begin
                oorNext = (q.oorCnt >= persLimit(q.alarm_persistence[3:0])) ? q.oorCnt
                                                               : q.oorCnt + 6'h01;
                hit     = (oorNext >= persLimit(q.alarm_persistence[3:0]));  // RL17
            end else begin
                oorNext = 6'h00;  // RL20
            end
            d.oorCnt  = oorNext;
            d.tick    = 20'h00000;
            d.longIdx = 4'h0;
            if (d.enable[BIT_WAIT_EN]) begin
                d.phase   = PH_WAIT;  // RL3
                d.stepIdx = d.wait_time;
            end else begin
                d.phase   = PH_INTEG;  // RL20
                d.stepIdx = d.itime;
            end
        end

        // alarm flag: clear command, set wins
        if (clearReq) begin
            d.alarm = 1'b0;  // RL18
        end
        if (hit && q.enable[BIT_ALARM_MASK]) begin
            d.alarm = 1'b1;  // RL2 RL13 RL21
        end

        // sleep after alarm; a host write of the enable register takes precedence
        if (integEnd && q.enable[BIT_SLEEP_ALARM] && d.alarm && !enableWrite) begin
            sleepNow                 = 1'b1;
            d.enable[BIT_OSC_POWER]  = 1'b0;  // RL1
            d.phase                  = PH_IDLE;
            d.valid                  = 1'b1;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q <= STATE_RESET;  // RL8 RL11
        end else if (clkEn) begin
            q <= d;
        end
    end

    // outputs
    assign regRdData = q.rdData;
    assign oscRun    = q.enable[BIT_OSC_POWER];                               // RL5
    assign adcRun    = q.enable[BIT_OSC_POWER] && (q.phase == PH_INTEG);     // RL4 RL5
    assign intPinOut = 1'b0;
    assign intPinOeN = !q.alarm;                                              // RL13 RL21

    // checks
    default clocking cb @(posedge clk_sys iff clkEn); endclocking
    default disable iff (!rstSync_n);

    // sequencing, alarm flag and sleep
    a_power_gates_run: assert property ( // RL5
        !q.enable[BIT_OSC_POWER]
        |-> !adcRun && q.phase == PH_IDLE)
        else $error("converter running with power off");
    a_alarm_needs_mask: assert property ( // RL2
        $rose(q.alarm)
        |-> $past(q.enable[BIT_ALARM_MASK]))
        else $error("alarm raised while masked");
    a_clear_cmd_acts: assert property ( // RL18
        clearReq && !(hit && q.enable[BIT_ALARM_MASK])
        |=> !q.alarm && intPinOeN)
        else $error("clear command did not drop alarm");
    a_alarm_holds: assert property ( // RL21
        q.alarm && !clearReq
        |=> q.alarm && !intPinOeN)
        else $error("alarm dropped without clear");
    a_sleep_powers_down: assert property ( // RL1
        sleepNow
        |=> !oscRun ##1 !adcRun)
        else $error("no power-down after alarm");
    a_every_cycle_alarm: assert property ( // RL16
        integEnd && q.alarm_persistence[3:0] == 4'h0 && q.enable[BIT_ALARM_MASK]
        |=> q.alarm)
        else $error("persistence zero did not alarm");
    a_in_range_resets: assert property ( // RL20
        integEnd && q.alarm_persistence[3:0] != 4'h0 && !outOfRange
        |=> q.oorCnt == 6'h00)
        else $error("in-range result kept count");
    a_wait_off_leaves: assert property ( // RL3
        q.phase == PH_WAIT && !q.enable[BIT_WAIT_EN]
        && q.enable[BIT_MEAS_EN] && q.enable[BIT_OSC_POWER]
        |=> q.phase == PH_INTEG)
        else $error("wait continued after disable");
    a_measure_off_idle: assert property ( // RL4 RL19
        !q.enable[BIT_MEAS_EN]
        |-> q.phase == PH_IDLE && !q.valid)
        else $error("cycle running with measurement off");
    a_single_step_integ: assert property ( // RL7
        $rose(q.phase == PH_INTEG) && q.stepIdx == STEP_IDX_LAST
        && q.tick == 20'h00000 && STEP_CYCLES_P == 4
        |-> ##3 integEnd)
        else $error("single step integration length wrong");

    // integration stepping, capture and wait stepping
    a_integ_counts_up: assert property ( // RL7
        q.phase == PH_INTEG && stepEnd && q.stepIdx != STEP_IDX_LAST && !enableWrite
        |=> q.stepIdx == $past(q.stepIdx) + 8'h01)
        else $error("integration step not advanced");
    a_ch0_saturates: assert property ( // RL7
        integEnd && ch0Raw > CH0_SAT
        |=> q.ch0 == CH0_SAT[15:0])
        else $error("channel 0 result not saturated");
    a_valid_on_capture: assert property ( // RL19
        integEnd
        |=> q.valid)
        else $error("valid flag missing after integration");
    a_idle_leaves: assert property ( // RL4 RL20
        q.phase == PH_IDLE && q.enable[BIT_OSC_POWER] && q.enable[BIT_MEAS_EN] && !enableWrite
        |=> q.phase == PH_INTEG)
        else $error("enabled cycle did not start");
    a_wait_entered: assert property ( // RL3
        integEnd && q.enable[BIT_WAIT_EN] && !enableWrite && !sleepNow
        |=> q.phase == PH_WAIT)
        else $error("wait period skipped");
    a_wait_long_stretch: assert property ( // RL9
        q.phase == PH_WAIT && q.enable[BIT_WAIT_EN] && !enableWrite && stepEnd
        && q.cfg[BIT_LONG_WAIT] && q.longIdx != LONG_WAIT_LAST
        |=> q.phase == PH_WAIT && q.stepIdx == $past(q.stepIdx))
        else $error("long wait step not stretched");
    a_long_idx_range: assert property ( // RL9
        q.phase == PH_WAIT
        |-> q.longIdx <= LONG_WAIT_LAST)
        else $error("long wait sub-step out of range");
    a_wait_last_step: assert property ( // RL10 RL20
        q.phase == PH_WAIT && q.enable[BIT_WAIT_EN] && !enableWrite && stepEnd
        && q.stepIdx == STEP_IDX_LAST
        && (!q.cfg[BIT_LONG_WAIT] || q.longIdx == LONG_WAIT_LAST)
        |=> q.phase == PH_INTEG)
        else $error("wait did not end after last step");

    // alarm mask and status byte
    a_masked_quiet: assert property ( // RL2
        !q.enable[BIT_ALARM_MASK] && !q.alarm
        |=> !q.alarm)
        else $error("alarm set with mask off");
    a_status_bits: assert property ( // RL19
        regReq.rd && regReq.addr == ADDR_STATUS
        |=> regRdData[BIT_STAT_VALID] == $past(q.valid)
            && regRdData[BIT_STAT_ALARM] == $past(q.alarm))
        else $error("status byte does not show flags");

    // main scenarios reached
    c_alarm_raised: cover property ($rose(q.alarm));
    c_wait_entered: cover property (q.phase == PH_INTEG ##1 q.phase == PH_WAIT);
    c_long_wait_step: cover property (q.phase == PH_WAIT && q.longIdx == LONG_WAIT_LAST);
    c_sleep_event: cover property (sleepNow);
    c_persist_hit: cover property (integEnd && q.alarm_persistence[3:0] != 4'h0 && hit);

endmodule

// [hw/lsca_pkg.sv]
// package: register map, field positions, timing constants and types of the light sensor core
package lsca_pkg;

    // register offsets on the byte register port
    localparam logic [4:0] ADDR_ENABLE   = 5'h00;
    localparam logic [4:0] ADDR_ITIME    = 5'h01;
    localparam logic [4:0] ADDR_WAIT_TIME    = 5'h03;
    localparam logic [4:0] ADDR_THR_LL   = 5'h04;
    localparam logic [4:0] ADDR_THR_LH   = 5'h05;
    localparam logic [4:0] ADDR_THR_HL   = 5'h06;
    localparam logic [4:0] ADDR_THR_HH   = 5'h07;
    localparam logic [4:0] ADDR_ALARM_PERSISTENCE     = 5'h0C;
    localparam logic [4:0] ADDR_CONFIG   = 5'h0D;
    localparam logic [4:0] ADDR_STATUS   = 5'h13;
    localparam logic [4:0] ADDR_CH0_LO   = 5'h14;
    localparam logic [4:0] ADDR_CH0_HI   = 5'h15;

    // bit positions in the enable register
    localparam int BIT_OSC_POWER   = 0;
    localparam int BIT_MEAS_EN     = 1;
    localparam int BIT_WAIT_EN     = 3;
    localparam int BIT_ALARM_MASK  = 4;
    localparam int BIT_SLEEP_ALARM = 6;
    // bit positions in config and status
    localparam int BIT_LONG_WAIT   = 1;
    localparam int BIT_STAT_VALID  = 0;
    localparam int BIT_STAT_ALARM  = 4;

    // reset values
    localparam logic [7:0]  RST_ENABLE = 8'h00;
    localparam logic [7:0]  RST_ITIME  = 8'hFF;
    localparam logic [7:0]  RST_WAIT_TIME  = 8'hFF;
    localparam logic [7:0]  RST_ALARM_PERSISTENCE   = 8'h00;
    localparam logic [7:0]  RST_CONFIG = 8'h00;
    localparam logic [15:0] RST_THR    = 16'h0000;

    // special function command: type in bits 6:5, function in bits 4:0
    localparam logic [1:0] CMD_TYPE_SPECIAL = 2'h3;
    localparam logic [4:0] CMD_FN_INT_CLEAR = 5'h06;

    // timing: one step is 2.73 ms
    localparam int STEP_TIME_NS  = 2730000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] LONG_WAIT_LAST = 4'hB;   // twelve sub-steps, 0..11
    localparam logic [7:0] STEP_IDX_LAST  = 8'hFF;
    localparam logic [16:0] CH0_SAT       = 17'h0FFFF;
    localparam logic [3:0] ALARM_PERSISTENCE_DIRECT_MAX = 4'h3;
    localparam logic [5:0] ALARM_PERSISTENCE_STEP       = 6'h05;

    typedef enum logic [1:0] {PH_IDLE, PH_INTEG, PH_WAIT} lsca_phase_t;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } lsca_reg_req_t;

    // whole state of the core
    typedef struct packed {
        logic [7:0]  enable;
        logic [7:0]  itime;
        logic [7:0]  wait_time;
        logic [7:0]  cfg;
        logic [7:0]  alarm_persistence;
        logic [15:0] thrLow;
        logic [15:0] thrHigh;
        lsca_phase_t phase;
        logic [19:0] tick;
        logic [7:0]  stepIdx;
        logic [3:0]  longIdx;
        logic [5:0]  oorCnt;
        logic        alarm;
        logic        valid;
        logic [15:0] ch0;
        logic [7:0]  rdData;
    } lsca_state_t;

    localparam lsca_state_t STATE_RESET = '{
        enable: RST_ENABLE, itime: RST_ITIME, wait_time: RST_WAIT_TIME, cfg: RST_CONFIG,
        alarm_persistence: RST_ALARM_PERSISTENCE, thrLow: RST_THR, thrHigh: RST_THR, phase: PH_IDLE,
        tick: 20'h00000, stepIdx: 8'h00, longIdx: 4'h0, oorCnt: 6'h00,
        alarm: 1'b0, valid: 1'b0, ch0: 16'h0000, rdData: 8'h00};

endpackage
